//--- src/usi_indexer.sv
/*
  Unipolar stepper indexer top: synchronises the step/direction pins,
  walks the phase sequence, gates four low-side channels, runs the
  overcurrent, overheat and supply-low protection and offers status and
  control over an AHB-Lite slave.
  Assumes a single AHB-Lite master, the pins asynchronous to hclk, and
  the open-drain wires resolved outside from the enables.
*/
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module usi_indexer #(
	parameter int unsigned RETRY_CYC = usi_pkg::OC_RETRY_CYC,
	parameter int unsigned DEGL_CYC = usi_pkg::OC_DEGLITCH_CYC
) (
	input wire logic hclk, // Logic and bus clock
	input wire logic hresetn, // Power-up reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size, word only
	input wire logic hready, // Bus ready
	input wire logic [31:0] hwdata, // Write data
	output logic [31:0] hrdata, // Read data
	output logic hreadyout, // Slave ready
	output logic hresp, // Always OKAY
	input wire logic step, // Step pin
	input wire logic dir, // Direction pin
	input wire logic mode_select_lo, // Mode select low bit
	input wire logic mode_select_hi, // Mode select high bit
	input wire logic drive_enable_low, // Output enable, active low
	input wire logic reset_pin, // Indexer reset, active high
	input wire logic [3:0] overcurrent_guard, // Limit level per channel
	input wire logic overheat_guard, // Die too hot
	input wire logic supply_low_lockout, // Motor supply too low
	output logic channel_one, // Low-side driver 1 on
	output logic channel_two, // Low-side driver 2 on
	output logic channel_three, // Low-side driver 3 on
	output logic channel_four, // Low-side driver 4 on
	input wire logic home_position_flag_low_i, // Home wire level
	output logic home_position_flag_low_o, // Home drive value
	output logic home_position_flag_low_oe_n, // Home pulls low
	input wire logic fault_flag_low_i, // Fault wire level
	output logic fault_flag_low_o, // Fault drive value
	output logic fault_flag_low_oe_n // Fault pulls low
);
	import usi_pkg::*;

	// Next position in the sequence of the given mode
	function automatic logic [2:0] usi_next_phase(
		input usi_mode_t m,
		input logic [2:0] p,
		input logic up
	);
		logic [1:0] q;
		q = p[1:0];
		if (m == USI_MODE_HALF)
			return up ? 3'(p + 3'h1) : 3'(p - 3'h1);
		else
			return {1'b0, up ? 2'(q + 2'h1) : 2'(q - 2'h1)};
	endfunction

	// Channel pattern, bit 0 is channel one
	function automatic logic [3:0] usi_pattern(
		input usi_mode_t m,
		input logic [2:0] p
	);
		logic [3:0] r;
		r = 4'h0;
		unique case (m)
		USI_MODE_FULL:
			unique case (p[1:0])
			2'h0: r = 4'h9;
			2'h1: r = 4'h3;
			2'h2: r = 4'h6;
			2'h3: r = 4'hC;
			endcase
		USI_MODE_HALF:
			unique case (p)
			3'h0: r = 4'h1;
			3'h1: r = 4'h3;
			3'h2: r = 4'h2;
			3'h3: r = 4'h6;
			3'h4: r = 4'h4;
			3'h5: r = 4'hC;
			3'h6: r = 4'h8;
			3'h7: r = 4'h9;
			endcase
		USI_MODE_WAVE:
			r = 4'(4'h1 << p[1:0]);
		USI_MODE_RSVD:
			r = 4'h0; // Never latched; kept safe
		endcase
		return r;
	endfunction

	// Pin synchroniser, two stages, then a step edge stage
	logic [SY_W-1:0] sync1_ff; // First stage, read by second only
	logic [SY_W-1:0] sync2_ff; // Settled pin levels
	logic step_d_ff; // Step level one cycle back
	logic home_s1_ff; // Home wire first stage
	logic home_s2_ff; // Home wire settled

	// Indexer state
	logic [2:0] phase_ff; // Position, 0 is home
	usi_mode_t mode_ff; // Mode taken at last step or clear
	logic [15:0] steps_ff; // Steps taken since clear

	// Outputs and control
	logic [3:0] chan_ff; // Registered channel drive
	logic home_ff; // Registered home pull
	logic fault_ff; // Registered fault pull
	logic force_off_ff; // Software channel kill

	// Bus data phase
	logic wr_pend_ff; // Write waiting for its data
	logic [7:0] wr_addr_ff; // Its offset
	logic [31:0] rdata_ff; // Read data for the data phase

	// Named views of the settled pins
	logic s_step, s_dir, s_en_low, s_reset, s_overheat, s_supply_low_lockout;
	logic [3:0] s_oc;
	usi_mode_t s_mode;

	// Derived conditions
	logic step_rise; // Synchronised rising edge of step, not yet qualified
	logic step_take; // Edge that moves the indexer
	logic logic_clear; // Pin reset or supply low
	logic [3:0] oc_fault; // Per channel overcurrent hold-off
	logic any_fault; // Any fault blocks stepping
	logic bus_take; // Address phase accepted
	logic wr_data; // Write data present now
	logic clear_oc_pulse; // Software overcurrent clear
	logic clear_steps_pulse; // Software step count clear
	logic [3:0] pattern; // Channels of present state

	assign s_step = sync2_ff[SY_STEP];
	assign s_dir = sync2_ff[SY_DIR];
	assign s_mode = usi_mode_t'({sync2_ff[SY_MODE_HI], sync2_ff[SY_MODE_LO]});
	assign s_en_low = sync2_ff[SY_EN_LOW];
	assign s_reset = sync2_ff[SY_RESET];
	assign s_oc = sync2_ff[SY_OC_LSB +: 4];
	assign s_overheat = sync2_ff[SY_OVERHEAT];
	assign s_supply_low_lockout = sync2_ff[SY_SUPPLY_LOW];

	// Two flops on every pin before any logic looks at it
	always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
	begin
		sync1_ff <= '0;
		sync2_ff <= '0;
		step_d_ff <= 1'b0;
		home_s1_ff <= 1'b1;
		home_s2_ff <= 1'b1;
	end
	else
	begin
		sync1_ff <= {fault_flag_low_i, supply_low_lockout, overheat_guard,
			overcurrent_guard, reset_pin, drive_enable_low,
			mode_select_hi, mode_select_lo, dir, step};
		sync2_ff <= sync1_ff;
		step_d_ff <= sync2_ff[SY_STEP];
		home_s1_ff <= home_position_flag_low_i;
		home_s2_ff <= home_s1_ff;
	end

	// Pin reset and supply low both send the indexer home and clear the step count and the guards
	assign logic_clear = s_reset | s_supply_low_lockout;

	// Direction and mode travel the same two stages as step, so they are
	// seen as they stood at the step edge; the controller's setup covers it
	assign step_rise = s_step & ~step_d_ff;

	assign any_fault = (|oc_fault) | s_overheat;

	// One expression feeds both the indexer and the step counter, so the
	// count can never drift from the position that software reads back
	assign step_take = step_rise && !any_fault && s_mode != USI_MODE_RSVD;

	// Indexer: one state per qualified edge, held otherwise
	always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
	begin
		phase_ff <= PHASE_HOME;
		mode_ff <= USI_MODE_FULL;
	end
	else if (logic_clear)
	begin
		phase_ff <= PHASE_HOME;
		mode_ff <= s_mode == USI_MODE_RSVD ? mode_ff : s_mode;
	end
	else if (step_take)
	begin
		// Enable pin plays no part here: the indexer runs while disabled
		phase_ff <= usi_next_phase(s_mode, phase_ff, s_dir);
		mode_ff <= s_mode;
	end
	// Reserved code, faults and no edge: hold

	// Count of steps taken, for software
	always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
		steps_ff <= STEPS_RST;
	else if (logic_clear || clear_steps_pulse)
		steps_ff <= STEPS_RST;
	else if (step_take)
		steps_ff <= steps_ff + 16'h0001;

	// One guard per channel; the clear wins over a trip in its cycle
	for (genvar g = 0; g < 4; g++)
	begin : g_guard
		usi_oc_guard #(
			.DEGL_CYC(DEGL_CYC),
			.RETRY_CYC(RETRY_CYC),
			.CNT_W(GUARD_CNT_W)
		) u_guard (
			.hclk(hclk),
			.hresetn(hresetn),
			.clear(logic_clear | clear_oc_pulse),
			.limit(s_oc[g]),
			.fault(oc_fault[g])
		);
	end

	assign pattern = usi_pattern(mode_ff, phase_ff);

	// Channel drive: pattern gated by enable, software, protection
	always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
		chan_ff <= 4'h0;
	else if (s_supply_low_lockout || s_overheat || s_en_low || force_off_ff)
		chan_ff <= 4'h0;
	else
		chan_ff <= pattern & ~oc_fault;

	assign channel_one = chan_ff[0];
	assign channel_two = chan_ff[1];
	assign channel_three = chan_ff[2];
	assign channel_four = chan_ff[3];

	// Open-drain flags; a home flag that follows the state alone
	always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
	begin
		home_ff <= 1'b1;
		fault_ff <= 1'b0;
	end
	else
	begin
		home_ff <= (phase_ff == PHASE_HOME);
		// Supply low shuts all circuitry, so the fault pull lets go too
		fault_ff <= any_fault & ~s_supply_low_lockout;
	end

	assign home_position_flag_low_o = 1'b0;
	assign home_position_flag_low_oe_n = ~home_ff;
	assign fault_flag_low_o = 1'b0;
	assign fault_flag_low_oe_n = ~fault_ff;

	// AHB-Lite: zero wait states, OKAY always
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign bus_take = hsel & hready & htrans[1];
	assign wr_data = wr_pend_ff;
	assign clear_oc_pulse = wr_data && wr_addr_ff == REG_CTRL &&
		hwdata[CTRL_CLEAR_OC];
	assign clear_steps_pulse = wr_data && wr_addr_ff == REG_CTRL &&
		hwdata[CTRL_CLEAR_STEPS];
	assign hrdata = rdata_ff;

	// Address phase: note writes, fetch read data for the data phase
	always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
	begin
		wr_pend_ff <= 1'b0;
		wr_addr_ff <= 8'h00;
		rdata_ff <= 32'h0000_0000;
	end
	else
	begin
		// Writes above the map are dropped like reads there, so a stray
		// address can never alias onto the control register
		wr_pend_ff <= bus_take & hwrite & (haddr[31:8] == 24'h00_0000);
		wr_addr_ff <= haddr[7:0];
		rdata_ff <= 32'h0000_0000;
		// Full words only; hsize is not checked, narrower reads see a word
		if (bus_take && !hwrite && haddr[31:8] == 24'h00_0000)
		begin
			unique case (haddr[7:0])
			REG_STATUS:
			begin
				rdata_ff[ST_PHASE_LSB +: 3] <= phase_ff;
				rdata_ff[ST_HOME] <= ~home_s2_ff;
				rdata_ff[ST_OC_LSB +: 4] <= oc_fault;
				rdata_ff[ST_OVERHEAT] <= s_overheat;
				rdata_ff[ST_SUPPLY_LOW] <= s_supply_low_lockout;
				rdata_ff[ST_MODE_LSB +: 2] <= mode_ff;
				rdata_ff[ST_FAULT_PIN] <= ~sync2_ff[SY_FAULT_PIN];
				rdata_ff[ST_RESET_PIN] <= s_reset;
			end
			REG_CTRL:
				rdata_ff[CTRL_FORCE_OFF] <= force_off_ff;
			REG_STEPS:
				rdata_ff[15:0] <= steps_ff;
			default:
				rdata_ff <= 32'h0000_0000; // Unmapped reads as zero
			endcase
		end
	end

	// Data phase of a control write; other offsets ignore writes
	always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
		force_off_ff <= CTRL_FORCE_OFF_RST;
	else if (wr_data && wr_addr_ff == REG_CTRL)
		force_off_ff <= hwdata[CTRL_FORCE_OFF];

	// hsize is accepted but unused: only word transfers are supported
	logic unused_hsize;
	assign unused_hsize = ^hsize;

endmodule // usi_indexer

//--- shared/usi_pkg.sv
/*
  Shared constants and types of the unipolar stepper indexer: timing,
  register map, field positions, reset values and the mode and guard
  encodings.
  Assumes a 25 MHz logic clock; all cycle counts are derived from it.
*/
package usi_pkg;

	// Logic clock rate
	localparam int unsigned CLK_MHZ = 25;

	// Overcurrent deglitch, ns, and retry interval, us
	localparam int unsigned OC_DEGLITCH_NS = 3500;
	localparam int unsigned OC_RETRY_US = 1200;

	// A least time rounds up to whole cycles
	localparam int unsigned OC_DEGLITCH_CYC =
		(OC_DEGLITCH_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned OC_RETRY_CYC = OC_RETRY_US * CLK_MHZ;

	// Width of the guard counters, room for the retry count
	localparam int unsigned GUARD_CNT_W = 16;

	// Register byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CTRL = 8'h04;
	localparam logic [7:0] REG_STEPS = 8'h08;

	// Control register fields
	localparam int unsigned CTRL_FORCE_OFF = 0;
	localparam int unsigned CTRL_CLEAR_OC = 1;
	localparam int unsigned CTRL_CLEAR_STEPS = 2;
	localparam logic CTRL_FORCE_OFF_RST = 1'b0;

	// Status register fields
	localparam int unsigned ST_PHASE_LSB = 0;
	localparam int unsigned ST_HOME = 3;
	localparam int unsigned ST_OC_LSB = 4;
	localparam int unsigned ST_OVERHEAT = 8;
	localparam int unsigned ST_SUPPLY_LOW = 9;
	localparam int unsigned ST_MODE_LSB = 10;
	localparam int unsigned ST_FAULT_PIN = 12;
	localparam int unsigned ST_RESET_PIN = 13;

	// Positions in the synchroniser bank
	localparam int unsigned SY_STEP = 0;
	localparam int unsigned SY_DIR = 1;
	localparam int unsigned SY_MODE_LO = 2;
	localparam int unsigned SY_MODE_HI = 3;
	localparam int unsigned SY_EN_LOW = 4;
	localparam int unsigned SY_RESET = 5;
	localparam int unsigned SY_OC_LSB = 6;
	localparam int unsigned SY_OVERHEAT = 10;
	localparam int unsigned SY_SUPPLY_LOW = 11;
	localparam int unsigned SY_FAULT_PIN = 12;
	localparam int unsigned SY_W = 13;

	// Indexer position after any reset (state 1, home)
	localparam logic [2:0] PHASE_HOME = 3'h0;
	localparam logic [15:0] STEPS_RST = 16'h0000;

	// Step modes as selected by {mode_select_hi, mode_select_lo}
	typedef enum logic [1:0] {
		USI_MODE_FULL = 2'b00,
		USI_MODE_HALF = 2'b01,
		USI_MODE_WAVE = 2'b10,
		USI_MODE_RSVD = 2'b11
	} usi_mode_t;

	// Overcurrent guard states
	typedef enum logic [0:0] {
		USI_GUARD_WATCH = 1'b0,
		USI_GUARD_RETRY = 1'b1
	} usi_guard_t;

endpackage

//--- src/usi_oc_guard.sv
/*
  One overcurrent guard: deglitches a channel's current-limit level and,
  once tripped, holds the channel off for the retry interval.
  Assumes the limit input is already synchronous to hclk.
*/
`timescale 1ns/100ps
module usi_oc_guard #(
	parameter int unsigned DEGL_CYC = usi_pkg::OC_DEGLITCH_CYC,
	parameter int unsigned RETRY_CYC = usi_pkg::OC_RETRY_CYC,
	parameter int unsigned CNT_W = usi_pkg::GUARD_CNT_W
) (
	input wire logic hclk, // Logic clock
	input wire logic hresetn, // Async reset, active low
	input wire logic clear, // Immediate fault clear
	input wire logic limit, // Current limit active
	output logic fault // Channel held off
);
	import usi_pkg::*;

	usi_guard_t state_ff; // Watch or retry
	logic [CNT_W-1:0] cnt_ff; // Deglitch or retry count

	// Tracks the limit level, then times the off period
	always_ff @(posedge hclk or negedge hresetn)
	if (!hresetn)
	begin
		state_ff <= USI_GUARD_WATCH;
		cnt_ff <= '0;
	end
	else if (clear)
	begin
		// Clear beats a trip in the same cycle
		state_ff <= USI_GUARD_WATCH;
		cnt_ff <= '0;
	end
	else
	begin
		unique case (state_ff)
		USI_GUARD_WATCH:
		begin
			if (!limit)
				cnt_ff <= '0; // Glitch: start over
			else if (cnt_ff == CNT_W'(DEGL_CYC - 1))
			begin
				state_ff <= USI_GUARD_RETRY;
				cnt_ff <= '0;
			end
			else
				cnt_ff <= cnt_ff + 1'b1;
		end
		USI_GUARD_RETRY:
		begin
			if (cnt_ff == CNT_W'(RETRY_CYC - 1))
			begin
				state_ff <= USI_GUARD_WATCH;
				cnt_ff <= '0;
			end
			else
				cnt_ff <= cnt_ff + 1'b1;
		end
		endcase
	end

	assign fault = (state_ff == USI_GUARD_RETRY);

endmodule // usi_oc_guard

//--- tb/usi_indexer_monitor.sv
/* Pin checker of the stepper indexer.
   Assumes a deglitch count of at most 5 and a retry of at least 20. */
`timescale 1ns/100ps
module usi_indexer_monitor (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, low
	input wire logic step, // Step pin
	input wire logic reset_pin, // Indexer reset
	input wire logic drive_enable_low, // Enable, low
	input wire logic [3:0] overcurrent_guard, // Limits
	input wire logic overheat_guard, // Too hot
	input wire logic supply_low_lockout, // Supply low
	input wire logic channel_one, // Driver 1
	input wire logic channel_two, // Driver 2
	input wire logic channel_three, // Driver 3
	input wire logic channel_four, // Driver 4
	input wire logic home_position_flag_low_oe_n, // Home pull
	input wire logic fault_flag_low_oe_n // Fault pull
);
	// All drivers as one nibble
	wire logic [3:0] chans;
	assign chans = {channel_four, channel_three, channel_two, channel_one};
	// Pins pass two sync flops, so every span leaves a few cycles
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	AST_EN_GATE:
	assert property (drive_enable_low [*6] |-> chans == 4'h0)
		else $error("drivers on while disabled");
	// Home pattern never holds channel two or three
	AST_HOME_PAT:
	assert property (!home_position_flag_low_oe_n |-> chans[2:1] == 2'h0)
		else $error("home flag outside home state");
	AST_RST_HOME:
	assert property (reset_pin [*5] |-> !home_position_flag_low_oe_n)
		else $error("reset did not reach home");
	AST_SUP_OFF:
	assert property (supply_low_lockout [*5] |-> !chans && fault_flag_low_oe_n)
		else $error("supply low left circuitry on");
	AST_HEAT_OFF:
	assert property ((overheat_guard && !supply_low_lockout) [*5]
		|-> chans == 4'h0 && !fault_flag_low_oe_n)
		else $error("overheat not shut down");
	// A step only moves home after a rising edge
	AST_HOLD:
	assert property ((!step && !reset_pin && !supply_low_lockout) [*8]
		|=> $stable(home_position_flag_low_oe_n))
		else $error("state moved without a step");
	AST_OC_TRIP:
	assert property ($rose(overcurrent_guard[2]) ##0 (overcurrent_guard[2]
		&& !reset_pin && !supply_low_lockout) [*8]
		|-> ##3 !fault_flag_low_oe_n && !channel_three)
		else $error("limit not tripped after deglitch");
	AST_OC_CLR:
	assert property ((reset_pin && !overheat_guard && !supply_low_lockout) [*6]
		|-> fault_flag_low_oe_n)
		else $error("reset left fault flag low");
	// Main scenarios
	cover property ($rose(home_position_flag_low_oe_n));
	cover property (!fault_flag_low_oe_n ##1 fault_flag_low_oe_n);
	cover property (drive_enable_low ##1 !drive_enable_low);
endmodule // usi_indexer_monitor

bind usi_indexer usi_indexer_monitor u_mon (.hclk, .hresetn, .step,
	.reset_pin, .drive_enable_low, .overcurrent_guard, .overheat_guard,
	.supply_low_lockout, .channel_one, .channel_two, .channel_three,
	.channel_four, .home_position_flag_low_oe_n, .fault_flag_low_oe_n);

//--- tb/usi_step_host.sv
/* Motion controller model: issues step pulses with direction and mode.
   Assumes a 25 MHz hclk to time its pulses. */
`timescale 1ns/100ps
module usi_step_host (
	input wire logic hclk, // Logic clock
	output logic step, // Step pin
	output logic dir, // Direction pin
	output logic mode_select_lo, // Mode low bit
	output logic mode_select_hi // Mode high bit
);
	// Idle levels from time zero
	initial
	begin
		step = 1'b0;
		dir = 1'b1;
		mode_select_lo = 1'b0;
		mode_select_hi = 1'b0;
	end
	// One step; phases of 50 cycles keep well inside the rate limit
	task automatic pulse(input logic up, input logic [1:0] m);
		begin
			@(posedge hclk);
			dir <= up;
			{mode_select_hi, mode_select_lo} <= m;
			repeat (30) @(posedge hclk);
			step <= 1'b1;
			repeat (50) @(posedge hclk);
			step <= 1'b0;
			repeat (50) @(posedge hclk);
		end
	endtask
endmodule // usi_step_host

//--- tb/usi_indexer_test.sv
/* Self-checking bench of the stepper indexer: sequences, gating, guards.
   Assumes pull-ups on both open-drain flags. */
`timescale 1ns/100ps
`define CHK(g, e, s) \
	begin \
		num_checks++; \
		if ((g) !== (e)) \
		begin \
			miscompares++; \
			$display("mismatch %0t %s", $time, s); \
		end \
	end
module usi_indexer_test;
	// Nibble per state, state 1 lowest: full, half, wave
	localparam logic [31:0] TAB [3] = '{32'hC639, 32'h98C46231, 32'h8421};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic drive_enable_low = 1'b0;
	logic reset_pin = 1'b0;
	logic [3:0] overcurrent_guard = 4'h0;
	logic overheat_guard = 1'b0;
	logic supply_low_lockout = 1'b0;
	logic [31:0] hrdata;
	logic hreadyout, hresp, step, dir, msl, msh;
	logic ch1, ch2, ch3, ch4, home_o, home_oe_n, fault_o, fault_oe_n;
	int miscompares = 0;
	int num_checks = 0;
	// Open-drain wires rest high when released
	wire logic home_w = home_oe_n ? 1'b1 : home_o;
	wire logic fault_w = fault_oe_n ? 1'b1 : fault_o;
	wire logic [3:0] chans = {ch4, ch3, ch2, ch1};
	always #20 hclk = ~hclk;
	usi_step_host u_host (.hclk(hclk), .step(step), .dir(dir),
		.mode_select_lo(msl), .mode_select_hi(msh));
	usi_indexer #(.RETRY_CYC(50), .DEGL_CYC(5)) u_dut (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .step(step), .dir(dir), .mode_select_lo(msl),
		.mode_select_hi(msh), .drive_enable_low(drive_enable_low),
		.reset_pin(reset_pin), .overcurrent_guard(overcurrent_guard),
		.overheat_guard(overheat_guard),
		.supply_low_lockout(supply_low_lockout), .channel_one(ch1),
		.channel_two(ch2), .channel_three(ch3), .channel_four(ch4),
		.home_position_flag_low_i(home_w),
		.home_position_flag_low_o(home_o),
		.home_position_flag_low_oe_n(home_oe_n),
		.fault_flag_low_i(fault_w), .fault_flag_low_o(fault_o),
		.fault_flag_low_oe_n(fault_oe_n));
	// Verdict and end of run
	task give_verdict;
		begin
			if (miscompares == 0 && num_checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// Bounded wait for hready sampled high
	task automatic wait_ready;
		int n;
		begin
			n = 0;
			do
			begin
				@(posedge hclk);
				n++;
			end
			while (hreadyout !== 1'b1 && n < 40);
			if (n >= 40)
			begin
				miscompares++;
				give_verdict;
			end
		end
	endtask
	// One single word transfer, read data taken at the data-phase edge
	task automatic ahb_xfer(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rd);
		begin
			@(posedge hclk);
			hsel <= 1'b1;
			htrans <= 2'h2;
			haddr <= a;
			hwrite <= w;
			wait_ready;
			htrans <= 2'h0;
			hwdata <= wd;
			wait_ready;
			rd = hrdata;
			`CHK(hresp, 1'b0, "response")
		end
	endtask
	// Drivers and home flag against the expected state
	task automatic chk_out(input int p, input int m);
		logic [31:0] t;
		begin
			t = TAB[m] >> (4 * p);
			`CHK(chans, t[3:0], "pattern")
			`CHK(home_w, (p == 0) ? 1'b0 : 1'b1, "home flag")
		end
	endtask
	// Holds channel three in limit past the deglitch time
	task automatic trip;
		begin
			overcurrent_guard <= 4'h4;
			repeat (10) @(posedge hclk);
			overcurrent_guard <= 4'h0;
		end
	endtask
	initial
	begin
		int m, n, k, p;
		logic d;
		logic [31:0] rd;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		repeat (4) @(posedge hclk);
		chk_out(0, 0);
		ahb_xfer(1'b0, 32'h0, 32'h0, rd);
		`CHK(rd[13:0], 14'h0008, "status")
		// Each mode from home, up past the wrap and back down
		for (m = 0; m < 3; m++)
		begin
			n = (m == 1) ? 8 : 4;
			reset_pin <= 1'b1;
			u_host.pulse(1'b1, m[1:0]);
			reset_pin <= 1'b0;
			repeat (6) @(posedge hclk);
			chk_out(0, m);
			p = 0;
			for (k = 0; k < 2 * n + 2; k++)
			begin
				d = (k <= n);
				u_host.pulse(d, m[1:0]);
				p = d ? (p + 1) % n : (p + n - 1) % n;
				chk_out(p, m);
			end
		end
		// Disabled drivers, indexer still stepping
		drive_enable_low <= 1'b1;
		u_host.pulse(1'b1, 2'h2);
		u_host.pulse(1'b1, 2'h2);
		`CHK(chans, 4'h0, "enable")
		drive_enable_low <= 1'b0;
		repeat (6) @(posedge hclk);
		chk_out(2, 2);
		ahb_xfer(1'b0, 32'h8, 32'h0, rd);
		`CHK(rd[15:0], 16'h000C, "step count")
		ahb_xfer(1'b1, 32'h4, 32'h1, rd);
		ahb_xfer(1'b0, 32'h4, 32'h0, rd);
		`CHK(rd[2:0], 3'h1, "control")
		`CHK(chans, 4'h0, "force off")
		ahb_xfer(1'b1, 32'h4, 32'h4, rd);
		ahb_xfer(1'b0, 32'h8, 32'h0, rd);
		`CHK(rd[15:0], 16'h0000, "steps clear")
		ahb_xfer(1'b0, 32'hC, 32'h0, rd);
		`CHK(rd, 32'h0, "unmapped")
		u_host.pulse(1'b1, 2'h3);
		chk_out(2, 2);
		// Overheat blocks drivers and steps
		overheat_guard <= 1'b1;
		u_host.pulse(1'b1, 2'h2);
		`CHK(chans, 4'h0, "heat off")
		`CHK(fault_w, 1'b0, "heat flag")
		ahb_xfer(1'b0, 32'h0, 32'h0, rd);
		`CHK(rd[13:0], 14'h1902, "heat status")
		overheat_guard <= 1'b0;
		repeat (6) @(posedge hclk);
		chk_out(2, 2);
		trip;
		`CHK(fault_w, 1'b0, "oc flag")
		`CHK(chans, 4'h0, "oc off")
		ahb_xfer(1'b0, 32'h0, 32'h0, rd);
		`CHK(rd[7:4], 4'h4, "oc status")
		// This step lands inside the retry interval
		u_host.pulse(1'b1, 2'h2);
		chk_out(2, 2);
		`CHK(fault_w, 1'b1, "retry")
		trip;
		reset_pin <= 1'b1;
		repeat (6) @(posedge hclk);
		`CHK(fault_w, 1'b1, "oc reset")
		reset_pin <= 1'b0;
		u_host.pulse(1'b1, 2'h2);
		chk_out(1, 2);
		trip;
		supply_low_lockout <= 1'b1;
		repeat (6) @(posedge hclk);
		`CHK(chans, 4'h0, "supply off")
		`CHK(fault_w, 1'b1, "supply clear")
		supply_low_lockout <= 1'b0;
		repeat (6) @(posedge hclk);
		chk_out(0, 2);
		// Software clear ends the hold-off long before the retry time
		trip;
		ahb_xfer(1'b1, 32'h4, 32'h2, rd);
		repeat (3) @(posedge hclk);
		`CHK(fault_w, 1'b1, "software clear")
		give_verdict;
	end
endmodule // usi_indexer_test
